/* File: include/ocd_pkg.sv */
// ocd_pkg: constants, register map and carrier types of the outside-window detector
// assumes byte-wide registers reached over a plain strobe port on mclk
package ocd_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OCD_ADDR_STATUS   = 8'h2D;
  localparam logic [7:0] OCD_ADDR_CONFIG   = 8'h40;
  localparam logic [7:0] OCD_ADDR_UTH_LO   = 8'h41;
  localparam logic [7:0] OCD_ADDR_UTH_HI   = 8'h42;
  localparam logic [7:0] OCD_ADDR_LTH_LO   = 8'h43;
  localparam logic [7:0] OCD_ADDR_LTH_HI   = 8'h44;
  localparam logic [7:0] OCD_ADDR_DBCNT    = 8'h45;
  localparam logic [7:0] OCD_ADDR_IRQ_STAT = 8'h46;
  localparam logic [7:0] OCD_ADDR_IRQ_MASK = 8'h47;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int OCD_ST_ACTIVE   = 7;
  localparam int OCD_CFG_EN_LSB  = 0;
  localparam int OCD_CFG_LATCH   = 3;
  localparam int OCD_CFG_REL     = 4;
  localparam int OCD_CFG_WAKE    = 5;
  localparam int OCD_IRQ_ACTIVE  = 0;
  localparam int OCD_IRQ_CAPTURE = 1;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  OCD_RST_STATUS = 8'h00;
  localparam logic [5:0]  OCD_RST_CONFIG = 6'h00;
  localparam logic [11:0] OCD_RST_UTH    = 12'h7FF;
  localparam logic [11:0] OCD_RST_LTH    = 12'h800;
  localparam logic [7:0]  OCD_RST_DBCNT  = 8'h00;
  localparam logic [1:0]  OCD_RST_IRQ    = 2'h0;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  // index 2 is x, 1 is y, 0 is z
  typedef logic [2:0][11:0] ocd_axes_t;

  typedef struct packed {
    logic      valid;
    ocd_axes_t data;
  } ocd_sample_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ocd_req_t;

  typedef struct packed {
    logic       wake;
    logic       rel_mode;
    logic       latch;
    logic [2:0] axis_en;
  } ocd_cfg_t;

  function automatic logic signed [12:0] ocd_sext13(input logic [11:0] v);
    ocd_sext13 = $signed({v[11], v});
  endfunction : ocd_sext13

endpackage : ocd_pkg

/* File: verilog/ocd_axis_cmp.sv */
// ocd_axis_cmp: window compare of one axis value, a value equal to either threshold counts as outside
// assumes value and thresholds share the same signed 13-bit scale
`timescale 1ns/100ps
module ocd_axis_cmp (
  input  wire logic signed [12:0] value,
  input  wire logic signed [12:0] upper,
  input  wire logic signed [12:0] lower,
  input  wire logic               enable,
  output logic                    outside,
  output logic                    above
);
  import ocd_pkg::*;

  // ------------------------------------------------------------------
  // compare
  // ------------------------------------------------------------------
  always_comb begin
    above   = (value >= upper);
    outside = enable & ((value >= upper) | (value <= lower));
  end

endmodule : ocd_axis_cmp

/* File: verilog/ocd_debounce.sv */
// ocd_debounce: counts sample periods for which a condition holds
// assumes tick is a one-cycle pulse per output sample on the same clock
`timescale 1ns/100ps
module ocd_debounce (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       tick,
  input  wire logic       cond,
  input  wire logic [7:0] limit,
  output logic            hit
);
  import ocd_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
  } ocd_deb_state_t;

  ocd_deb_state_t state;
  ocd_deb_state_t next_state;

  // ------------------------------------------------------------------
  // periods counted include the current one
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    hit        = cond & (({1'b0, state.cnt} + 9'h001) >= {1'b0, limit});
    if (tick) begin
      if (!cond) begin
        next_state.cnt = 8'h00;
      end else if (state.cnt != 8'hFF) begin
        next_state.cnt = state.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule : ocd_debounce

/* File: verilog/ocd_top.sv */
// ocd_top: outside-of-window event detector for three acceleration axes
// assumes one sample strobe per output sample, same clock, and a byte
// register port whose read data appear the cycle after the read strobe
`timescale 1ns/100ps
module ocd_top (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire ocd_pkg::ocd_sample_t sample,
  input  wire ocd_pkg::ocd_req_t    req,
  output logic [7:0]                rdata,
  output logic                      irq,
  output logic                      sleep_timer_restart,
  output logic                      outside_window_active
);
  import ocd_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    ocd_cfg_t   cfg;
    logic [11:0] uth;
    logic [11:0] lth;
    logic [7:0]  dbcnt;
    ocd_axes_t   prev;
    logic [2:0]  flag;
    logic [2:0]  pol;
    logic        active;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [7:0]  rdata;
    logic        irq;
    logic        wake_pulse;
  } ocd_top_state_t;

  ocd_top_state_t state;
  ocd_top_state_t next_state;

  logic signed [2:0][12:0] value;
  logic [2:0]              outside;
  logic [2:0]              above;
  logic                    any_outside;
  logic                    deb_hit;

  // ------------------------------------------------------------------
  // status byte assembly
  // ------------------------------------------------------------------
  function automatic logic [7:0] ocd_status_byte(
    input logic       act,
    input logic [2:0] flg,
    input logic [2:0] pl
  );
    logic [7:0] b;
    b = OCD_RST_STATUS;
    b[OCD_ST_ACTIVE] = act;
    for (int i = 0; i < 3; i++) begin
      b[2 * i + 1] = flg[i];
      b[2 * i]     = pl[i];
    end
    ocd_status_byte = b;
  endfunction : ocd_status_byte

  // ------------------------------------------------------------------
  // axis values and comparators
  // ------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (state.cfg.rel_mode) begin
        value[i] = ocd_sext13(sample.data[i]) - ocd_sext13(state.prev[i]);
      end else begin
        value[i] = ocd_sext13(sample.data[i]);
      end
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_axis
    ocd_axis_cmp u_cmp (
      .value   (value[g]),
      .upper   (ocd_sext13(state.uth)),
      .lower   (ocd_sext13(state.lth)),
      .enable  (state.cfg.axis_en[g]),
      .outside (outside[g]),
      .above   (above[g])
    );
  end

  assign any_outside = |outside;

  // ------------------------------------------------------------------
  // debounce
  // ------------------------------------------------------------------
  ocd_debounce u_deb (
    .mclk  (mclk),
    .rst_b (rst_b),
    .tick  (sample.valid),
    .cond  (any_outside),
    .limit (state.dbcnt),
    .hit   (deb_hit)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [2:0] set_flag;
    logic [2:0] newly;
    logic [1:0] ev;
    logic       status_rd;
    set_flag   = 3'h0;
    newly      = 3'h0;
    ev         = 2'h0;
    status_rd  = req.rd && (req.addr == OCD_ADDR_STATUS);
    next_state = state;
    next_state.wake_pulse = 1'b0;

    // register writes
    if (req.wr) begin
      if (req.addr == OCD_ADDR_CONFIG) begin
        next_state.cfg = req.wdata[5:0];
      end else if (req.addr == OCD_ADDR_UTH_LO) begin
        next_state.uth[7:0] = req.wdata;
      end else if (req.addr == OCD_ADDR_UTH_HI) begin
        next_state.uth[11:8] = req.wdata[3:0];
      end else if (req.addr == OCD_ADDR_LTH_LO) begin
        next_state.lth[7:0] = req.wdata;
      end else if (req.addr == OCD_ADDR_LTH_HI) begin
        next_state.lth[11:8] = req.wdata[3:0];
      end else if (req.addr == OCD_ADDR_DBCNT) begin
        next_state.dbcnt = req.wdata;
      end else if (req.addr == OCD_ADDR_IRQ_STAT) begin
        next_state.irq_stat = state.irq_stat & ~req.wdata[1:0];
      end else if (req.addr == OCD_ADDR_IRQ_MASK) begin
        next_state.irq_mask = req.wdata[1:0];
      end
    end

    // latched flags cleared by a status read; a same-cycle set wins below
    if (status_rd && state.cfg.latch) begin
      next_state.flag = 3'h0;
    end

    // per-sample evaluation
    if (sample.valid) begin
      next_state.prev   = sample.data;
      next_state.active = deb_hit;
      if (deb_hit) begin
        set_flag = outside;
        if (state.cfg.latch) begin
          newly           = outside & ~state.flag;
          next_state.flag = next_state.flag | outside;
        end else begin
          newly           = outside & ~state.flag;
          next_state.flag = outside;
        end
        for (int i = 0; i < 3; i++) begin
          if (newly[i]) begin
            next_state.pol[i] = above[i];
          end
        end
        if (state.cfg.wake) begin
          next_state.wake_pulse = 1'b1;
        end
      end
      ev[OCD_IRQ_ACTIVE]  = deb_hit & ~state.active;
      ev[OCD_IRQ_CAPTURE] = |set_flag;
    end

    // sticky events, set wins over a write-one clear
    next_state.irq_stat = next_state.irq_stat | ev;
    next_state.irq      = |(next_state.irq_stat & next_state.irq_mask);

    // read data, one cycle after the strobe
    next_state.rdata = 8'h00;
    if (req.rd) begin
      if (req.addr == OCD_ADDR_STATUS) begin
        next_state.rdata = ocd_status_byte(state.active, state.flag, state.pol);
      end else if (req.addr == OCD_ADDR_CONFIG) begin
        next_state.rdata = {2'b00, state.cfg};
      end else if (req.addr == OCD_ADDR_UTH_LO) begin
        next_state.rdata = state.uth[7:0];
      end else if (req.addr == OCD_ADDR_UTH_HI) begin
        next_state.rdata = {4'h0, state.uth[11:8]};
      end else if (req.addr == OCD_ADDR_LTH_LO) begin
        next_state.rdata = state.lth[7:0];
      end else if (req.addr == OCD_ADDR_LTH_HI) begin
        next_state.rdata = {4'h0, state.lth[11:8]};
      end else if (req.addr == OCD_ADDR_DBCNT) begin
        next_state.rdata = state.dbcnt;
      end else if (req.addr == OCD_ADDR_IRQ_STAT) begin
        next_state.rdata = {6'h00, state.irq_stat};
      end else if (req.addr == OCD_ADDR_IRQ_MASK) begin
        next_state.rdata = {6'h00, state.irq_mask};
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state          <= '0;
      state.cfg      <= OCD_RST_CONFIG;
      state.uth      <= OCD_RST_UTH;
      state.lth      <= OCD_RST_LTH;
      state.dbcnt    <= OCD_RST_DBCNT;
      state.irq_stat <= OCD_RST_IRQ;
      state.irq_mask <= OCD_RST_IRQ;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign rdata                 = state.rdata;
  assign irq                   = state.irq;
  assign sleep_timer_restart   = state.wake_pulse;
  assign outside_window_active = state.active;

endmodule : ocd_top

/* File: dv/ocd_checker.sv */
// ocd_checker: port assertions for the outside-window detector
// assumes it is bound to ocd_top, one clock, async active-low reset
`timescale 1ns/100ps
module ocd_checker (
  input wire logic                 mclk,
  input wire logic                 rst_b,
  input wire ocd_pkg::ocd_sample_t sample,
  input wire ocd_pkg::ocd_req_t    req,
  input wire logic [7:0]           rdata,
  input wire logic                 irq,
  input wire logic                 sleep_timer_restart,
  input wire logic                 outside_window_active
);
  import ocd_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ----------------
  // sequences
  // ----------------
  sequence s_status_read;
    req.rd && req.addr == OCD_ADDR_STATUS && !sample.valid;
  endsequence
  sequence s_restart;
    sample.valid ##1 sleep_timer_restart;
  endsequence
  // ----------------
  // properties
  // ----------------
  property p_rd_idle;
    !$past(req.rd) |-> rdata == 8'h00;
  endproperty
  property p_status_read;
    s_status_read |=> rdata[7] == $past(outside_window_active) && !rdata[6];
  endproperty
  property p_unmapped;
    req.rd && req.addr == 8'h10 |=> rdata == 8'h00;
  endproperty
  property p_restart_src;
    sleep_timer_restart |-> $past(sample.valid);
  endproperty
  property p_restart_act;
    sleep_timer_restart |-> outside_window_active;
  endproperty
  property p_restart_once;
    s_restart ##0 !sample.valid |=> !sleep_timer_restart;
  endproperty
  property p_act_step;
    $changed(outside_window_active) |-> $past(sample.valid);
  endproperty
  property p_irq_src;
    $rose(irq) |-> $past(sample.valid) || $past(req.wr);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_status_read: assert property (p_status_read) else $error("status byte wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_restart_src: assert property (p_restart_src) else $error("restart without sample");
  a_restart_act: assert property (p_restart_act) else $error("restart while idle");
  a_restart_once: assert property (p_restart_once) else $error("restart too long");
  a_act_step: assert property (p_act_step) else $error("active moved off sample");
  a_irq_src: assert property (p_irq_src) else $error("irq without cause");
endmodule : ocd_checker

bind ocd_top ocd_checker u_chk (
  .mclk                  (mclk),
  .rst_b                 (rst_b),
  .sample                (sample),
  .req                   (req),
  .rdata                 (rdata),
  .irq                   (irq),
  .sleep_timer_restart   (sleep_timer_restart),
  .outside_window_active (outside_window_active)
);

/* File: dv/ocd_host.sv */
// ocd_host: host processor model on the byte register port
// assumes read data stand only in the cycle after the read strobe
`timescale 1ns/100ps
module ocd_host (
  input  wire logic         mclk,
  output ocd_pkg::ocd_req_t req,
  input  wire logic [7:0]   rdata
);
  import ocd_pkg::*;
  initial req = '0;
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge mclk);
    req <= '{a, d, w, ~w};
    @(posedge mclk);
    req <= '{~a, ~d, 1'b0, 1'b0};
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(a, 8'h00, 1'b0);
    #1;
    d = rdata;
  endtask : rd
endmodule : ocd_host

/* File: dv/ocd_top_test.sv */
// ocd_top_test: table-driven bench for ocd_top
// assumes ocd_pkg, ocd_top, ocd_host and the bound checker
`timescale 1ns/100ps
module ocd_top_test;
  import ocd_pkg::*;
  typedef struct packed {
    logic [7:0] cfg;
    ocd_axes_t  d0;
    ocd_axes_t  d1;
    logic       wk;
    logic [7:0] st;
  } ocd_row_t;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  ocd_sample_t sample = '0;
  ocd_req_t    req;
  logic [7:0]  rdata;
  logic        irq;
  logic        wake;
  logic        active;
  logic        seen_wake;
  logic [7:0]  rv;
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;
  ocd_row_t    rows [10];
  always #2 mclk = ~mclk;
  ocd_top dut (.mclk(mclk), .rst_b(rst_b), .sample(sample), .req(req), .rdata(rdata),
    .irq(irq), .sleep_timer_restart(wake), .outside_window_active(active));
  ocd_host host (.mclk(mclk), .req(req), .rdata(rdata));
  // ----------------
  // tasks
  // ----------------
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic setup(input logic [7:0] cfg, input logic [7:0] dbc);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    host.wr(OCD_ADDR_CONFIG, cfg);
    host.wr(OCD_ADDR_UTH_LO, 8'h64);
    host.wr(OCD_ADDR_UTH_HI, 8'h00);
    host.wr(OCD_ADDR_LTH_LO, 8'h9C);
    host.wr(OCD_ADDR_LTH_HI, 8'h0F);
    host.wr(OCD_ADDR_DBCNT, dbc);
  endtask : setup
  task automatic smp(input ocd_axes_t d);
    @(posedge mclk);
    sample <= '{1'b1, d};
    @(posedge mclk);
    sample <= '{1'b0, ~d};
    #1;
    seen_wake = wake;
  endtask : smp
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  // ----------------
  // tests
  // ----------------
  initial begin
    rows = '{'{8'h27, 36'h0, 36'h064000000, 1'b1, 8'hB0},
             '{8'h07, 36'h0, 36'h000F9C000, 1'b0, 8'h88},
             '{8'h07, 36'h0, 36'hF9D063000, 1'b0, 8'h00},
             '{8'h06, 36'h0, 36'h0000007FF, 1'b0, 8'h00},
             '{8'h00, 36'h0, 36'h7FF8007FF, 1'b0, 8'h00},
             '{8'h07, 36'h0, 36'h000000800, 1'b0, 8'h82},
             '{8'h17, 36'h050000000, 36'h0A0000000, 1'b0, 8'h00},
             '{8'h17, 36'h050000000, 36'hFEC000000, 1'b0, 8'hA0},
             '{8'h07, 36'h0, 36'h065F9B064, 1'b0, 8'hBB},
             '{8'h27, 36'h0, 36'h063000000, 1'b0, 8'h00}};
    setup(8'h00, 8'h00);
    host.wr(OCD_ADDR_STATUS, 8'hFF);
    host.rd(OCD_ADDR_STATUS, rv);
    chk("status_ro", rv, 8'h00);
    host.rd(8'h10, rv);
    chk("unmapped", rv, 8'h00);
    host.rd(OCD_ADDR_LTH_HI, rv);
    chk("lth_hi", rv, 8'h0F);
    $display("register test done");
    foreach (rows[i]) begin
      setup(rows[i].cfg, 8'h00);
      smp(rows[i].d0);
      smp(rows[i].d1);
      chk("wake", {7'h0, seen_wake}, {7'h0, rows[i].wk});
      host.rd(OCD_ADDR_STATUS, rv);
      chk("status", rv, rows[i].st);
      $display("row %0d done", i);
    end
    setup(8'h07, 8'h03);
    repeat (2) smp(36'h064000000);
    chk("debounce_early", {7'h0, active}, 8'h00);
    smp(36'h064000000);
    chk("debounce_hit", {7'h0, active}, 8'h01);
    smp('0);
    repeat (2) smp(36'h064000000);
    chk("debounce_restart", {7'h0, active}, 8'h00);
    $display("debounce test done");
    setup(8'h0F, 8'h00);
    host.wr(OCD_ADDR_IRQ_MASK, 8'h01);
    smp(36'h064000000);
    smp(36'h000F9C000);
    smp(36'hF9C000000);
    chk("irq_set", {7'h0, irq}, 8'h01);
    host.rd(OCD_ADDR_IRQ_STAT, rv);
    chk("irq_stat", rv, 8'h03);
    host.rd(OCD_ADDR_STATUS, rv);
    chk("latched", rv, 8'hB8);
    host.rd(OCD_ADDR_STATUS, rv);
    chk("cleared", rv, 8'h90);
    host.wr(OCD_ADDR_IRQ_STAT, 8'h01);
    @(posedge mclk);
    #1;
    chk("irq_clear", {7'h0, irq}, 8'h00);
    host.rd(OCD_ADDR_IRQ_STAT, rv);
    chk("irq_stat_clear", rv, 8'h02);
    host.wr(OCD_ADDR_IRQ_MASK, 8'h00);
    smp(36'h064000000);
    @(posedge mclk);
    #1;
    chk("irq_masked", {7'h0, irq}, 8'h00);
    $display("latch test done");
    stop_test();
  end
endmodule : ocd_top_test
